// ==== hdl/fsi_defs.vh ====
// timing, state and pattern constants for the fieldbus slave status indicators
`ifndef FSI_DEFS_VH
`define FSI_DEFS_VH

// ----------------------------------------------------------------------------
// clock and pattern times
// ----------------------------------------------------------------------------
`define FSI_CLK_HZ        40000000
`define FSI_FLICKER_MS    11'h032
`define FSI_BLINK_MS      11'h0C8
`define FSI_FLASH_ON_MS   11'h0C8
`define FSI_FLASH_OFF_MS  11'h3E8
`define FSI_MS_CYCLES     (`FSI_CLK_HZ / 1000)

// ----------------------------------------------------------------------------
// lamp pattern codes
// ----------------------------------------------------------------------------
`define FSI_PAT_W         3
`define FSI_PAT_OFF       3'h0
`define FSI_PAT_ON        3'h1
`define FSI_PAT_FLICKER   3'h2
`define FSI_PAT_BLINK     3'h3
`define FSI_PAT_SINGLE    3'h4
`define FSI_PAT_DOUBLE    3'h5

// ----------------------------------------------------------------------------
// communication states
// ----------------------------------------------------------------------------
`define FSI_ST_W          2
`define FSI_ST_INIT       2'h0
`define FSI_ST_PREOP      2'h1
`define FSI_ST_SAFEOP     2'h2
`define FSI_ST_OP         2'h3

// ----------------------------------------------------------------------------
// error codes, lowest code first in priority after none
// ----------------------------------------------------------------------------
`define FSI_ERR_W         3
`define FSI_ERR_NONE      3'h0
`define FSI_ERR_CRIT      3'h1
`define FSI_ERR_CFG       3'h2
`define FSI_ERR_SYNC      3'h3
`define FSI_ERR_WDOG      3'h4

// ----------------------------------------------------------------------------
// process data limit
// ----------------------------------------------------------------------------
`define FSI_PD_MAX_BYTES  256
`define FSI_PD_LEN_W      9

`endif

// ==== hdl/fsi_lamp_pattern.v ====
// one lamp pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "fsi_defs.vh"

module fsi_lamp_pattern #(
	parameter integer MS_CYCLES = `FSI_MS_CYCLES
) (
	// clock and reset
	input  wire                   clk_sys,
	input  wire                   rst_b,
	// pattern select
	input  wire [`FSI_PAT_W-1:0]  pattern,
	// lamp drive
	output reg                    lamp_q
);

	// ------------------------------------------------------------------------
	// millisecond tick and phase counter
	// ------------------------------------------------------------------------
	localparam integer TICK_W    = $clog2(MS_CYCLES + 1);
	localparam integer TICK_LAST = MS_CYCLES - 1;

	reg [TICK_W-1:0]         tick_q;
	reg [10:0]               ms_q;
	reg [1:0]                step_q;
	reg [`FSI_PAT_W-1:0]     pat_q;
	reg                      lit_d;
	reg [10:0]               dur_d;
	reg [1:0]                steps_d;
	wire                     ms_end;
	wire                     seg_end;

	assign ms_end  = (tick_q == TICK_LAST[TICK_W-1:0]);
	assign seg_end = ms_end && (ms_q == dur_d - 11'h001);

	// segment table per pattern and step
	always @* begin
		lit_d   = 1'b0;
		dur_d   = `FSI_BLINK_MS;
		steps_d = 2'h1;
		case (pat_q)
			`FSI_PAT_FLICKER: begin
				dur_d   = `FSI_FLICKER_MS;
				lit_d   = ~step_q[0];
				steps_d = 2'h1;
			end
			`FSI_PAT_BLINK: begin
				dur_d   = `FSI_BLINK_MS;
				lit_d   = ~step_q[0];
				steps_d = 2'h1;
			end
			`FSI_PAT_SINGLE: begin
				lit_d   = (step_q == 2'h0);
				dur_d   = lit_d ? `FSI_FLASH_ON_MS : `FSI_FLASH_OFF_MS;
				steps_d = 2'h1;
			end
			`FSI_PAT_DOUBLE: begin
				lit_d   = ~step_q[0];
				dur_d   = (step_q == 2'h3) ? `FSI_FLASH_OFF_MS : `FSI_FLASH_ON_MS;
				steps_d = 2'h3;
			end
			`FSI_PAT_ON: begin
				lit_d = 1'b1;
			end
			default: begin
				lit_d = 1'b0;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tick_q <= {TICK_W{1'b0}};
			ms_q   <= 11'h000;
			step_q <= 2'h0;
			pat_q  <= `FSI_PAT_OFF;
			lamp_q <= 1'b0;
		end else begin
			pat_q  <= pattern;
			lamp_q <= lit_d;
			if (pattern != pat_q) begin
				tick_q <= {TICK_W{1'b0}};
				ms_q   <= 11'h000;
				step_q <= 2'h0;
			end else if (ms_end) begin
				tick_q <= {TICK_W{1'b0}};
				if (seg_end) begin
					ms_q   <= 11'h000;
					step_q <= (step_q == steps_d) ? 2'h0 : step_q + 2'h1;
				end else begin
					ms_q <= ms_q + 11'h001;
				end
			end else begin
				tick_q <= tick_q + {{(TICK_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // fsi_lamp_pattern

`default_nettype wire

// ==== hdl/fsi_status_indicators.v ====
// fieldbus slave state tracking and status lamp drive
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "fsi_defs.vh"

module fsi_status_indicators #(
	parameter integer MS_CYCLES    = `FSI_MS_CYCLES,
	parameter integer PD_MAX_BYTES = `FSI_PD_MAX_BYTES
) (
	// clock and reset
	input  wire                     clk_sys,
	input  wire                     rst_b,
	// master state command
	input  wire                     st_cmd_valid,
	input  wire [`FSI_ST_W-1:0]     st_cmd,
	// error condition
	input  wire [`FSI_ERR_W-1:0]    err_code,
	// port link and traffic
	input  wire                     in_link,
	input  wire                     in_activity,
	input  wire                     out_link,
	input  wire                     out_activity,
	// process data size request
	input  wire                     pd_cfg_valid,
	input  wire [`FSI_PD_LEN_W-1:0] pd_in_bytes,
	input  wire [`FSI_PD_LEN_W-1:0] pd_out_bytes,
	// status
	output reg  [`FSI_ST_W-1:0]     comm_state_q,
	output reg  [`FSI_PD_LEN_W-1:0] pd_in_len_q,
	output reg  [`FSI_PD_LEN_W-1:0] pd_out_len_q,
	output reg                      pd_cfg_err_q,
	output wire                     sdo_enable,
	output wire                     pdo_enable,
	output wire                     pdo_out_enable,
	// lamps
	output wire                     run_lamp,
	output wire                     err_lamp,
	output wire                     in_link_lamp,
	output wire                     out_link_lamp
);

	// ------------------------------------------------------------------------
	// communication state
	// ------------------------------------------------------------------------
	reg [`FSI_ST_W-1:0] comm_state_d;

	always @* begin
		comm_state_d = comm_state_q;
		if (st_cmd_valid) begin
			comm_state_d = st_cmd;
		end
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			comm_state_q <= `FSI_ST_INIT;
		end else begin
			comm_state_q <= comm_state_d;
		end
	end

	// ------------------------------------------------------------------------
	// object services
	// ------------------------------------------------------------------------
	// shared state test for the service enables
	function in_state;
		input [`FSI_ST_W-1:0] cur;
		input [`FSI_ST_W-1:0] want;
		begin
			in_state = (cur == want);
		end
	endfunction

	assign sdo_enable     = !in_state(comm_state_q, `FSI_ST_INIT);
	assign pdo_enable     = in_state(comm_state_q, `FSI_ST_SAFEOP) || in_state(comm_state_q, `FSI_ST_OP);
	assign pdo_out_enable = in_state(comm_state_q, `FSI_ST_OP);

	// ------------------------------------------------------------------------
	// process data size
	// ------------------------------------------------------------------------
	reg [`FSI_PD_LEN_W-1:0] pd_in_len_d;
	reg [`FSI_PD_LEN_W-1:0] pd_out_len_d;
	reg                     pd_cfg_err_d;

	function size_ok;
		input [`FSI_PD_LEN_W-1:0] len;
		begin
			size_ok = (len <= PD_MAX_BYTES[`FSI_PD_LEN_W-1:0]);
		end
	endfunction

	// oversize requests are refused whole, the old sizes stay
	always @* begin
		pd_in_len_d  = pd_in_len_q;
		pd_out_len_d = pd_out_len_q;
		pd_cfg_err_d = pd_cfg_err_q;
		if (pd_cfg_valid) begin
			if (size_ok(pd_in_bytes) && size_ok(pd_out_bytes)) begin
				pd_in_len_d  = pd_in_bytes;
				pd_out_len_d = pd_out_bytes;
				pd_cfg_err_d = 1'b0;
			end else begin
				pd_cfg_err_d = 1'b1;
			end
		end
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pd_in_len_q  <= {`FSI_PD_LEN_W{1'b0}};
			pd_out_len_q <= {`FSI_PD_LEN_W{1'b0}};
			pd_cfg_err_q <= 1'b0;
		end else begin
			pd_in_len_q  <= pd_in_len_d;
			pd_out_len_q <= pd_out_len_d;
			pd_cfg_err_q <= pd_cfg_err_d;
		end
	end

	// ------------------------------------------------------------------------
	// pattern selection
	// ------------------------------------------------------------------------
	reg  [`FSI_PAT_W-1:0] run_pat;
	reg  [`FSI_PAT_W-1:0] err_pat;
	wire [`FSI_PAT_W-1:0] in_pat;
	wire [`FSI_PAT_W-1:0] out_pat;

	function [`FSI_PAT_W-1:0] link_pat;
		input link;
		input act;
		begin
			if (!link)
				link_pat = `FSI_PAT_OFF;
			else if (act)
				link_pat = `FSI_PAT_FLICKER;
			else
				link_pat = `FSI_PAT_ON;
		end
	endfunction

	always @* begin
		case (comm_state_q)
			`FSI_ST_PREOP:  run_pat = `FSI_PAT_BLINK;
			`FSI_ST_SAFEOP: run_pat = `FSI_PAT_SINGLE;
			`FSI_ST_OP:     run_pat = `FSI_PAT_ON;
			default:        run_pat = `FSI_PAT_OFF;
		endcase
	end

	// error lamp mapping
	// codes above watchdog are unused and show as no error
	always @* begin
		case (err_code)
			`FSI_ERR_CRIT: err_pat = `FSI_PAT_ON;
			`FSI_ERR_CFG:  err_pat = `FSI_PAT_BLINK;
			`FSI_ERR_SYNC: err_pat = `FSI_PAT_SINGLE;
			`FSI_ERR_WDOG: err_pat = `FSI_PAT_DOUBLE;
			default:       err_pat = `FSI_PAT_OFF;
		endcase
	end

	// ------------------------------------------------------------------------
	// link patterns
	// ------------------------------------------------------------------------
	// link and traffic
	assign in_pat  = link_pat(in_link, in_activity);
	assign out_pat = link_pat(out_link, out_activity);

	// ------------------------------------------------------------------------
	// lamp generators
	// ------------------------------------------------------------------------
	// activity is a level; a single-cycle packet pulse keeps the link lamp lit and shows no visible flicker
	fsi_lamp_pattern #(.MS_CYCLES(MS_CYCLES)) u_run (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pattern (run_pat),
		.lamp_q  (run_lamp)
	);

	fsi_lamp_pattern #(.MS_CYCLES(MS_CYCLES)) u_err (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pattern (err_pat),
		.lamp_q  (err_lamp)
	);

	fsi_lamp_pattern #(.MS_CYCLES(MS_CYCLES)) u_in (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pattern (in_pat),
		.lamp_q  (in_link_lamp)
	);

	fsi_lamp_pattern #(.MS_CYCLES(MS_CYCLES)) u_out (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pattern (out_pat),
		.lamp_q  (out_link_lamp)
	);

endmodule // fsi_status_indicators

`default_nettype wire

// ==== verification/fsi_status_monitor.sv ====
// port assertions of the status indicator block
`timescale 1ns/1ps
`default_nettype none
module fsi_status_monitor #(
	parameter integer MS_CYCLES    = 4,
	parameter integer PD_MAX_BYTES = 256
) (
	// inputs
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       st_cmd_valid,
	input wire logic [1:0] st_cmd,
	input wire logic [2:0] err_code,
	input wire logic       in_link,
	input wire logic       in_activity,
	input wire logic       out_link,
	input wire logic       pd_cfg_valid,
	input wire logic [8:0] pd_in_bytes,
	input wire logic [8:0] pd_out_bytes,
	// outputs
	input wire logic [1:0] comm_state_q,
	input wire logic [8:0] pd_in_len_q,
	input wire logic [8:0] pd_out_len_q,
	input wire logic       pd_cfg_err_q,
	input wire logic       sdo_enable,
	input wire logic       pdo_enable,
	input wire logic       pdo_out_enable,
	input wire logic       run_lamp,
	input wire logic       err_lamp,
	input wire logic       in_link_lamp,
	input wire logic       out_link_lamp
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// a restarted pattern opens lit; two register stages delay it
	sequence lit_run;
		##3 in_link_lamp [*6];
	endsequence
	state_hold_a: assert property (!st_cmd_valid |=> $stable(comm_state_q)) else $error("state moved");
	state_take_a: assert property (st_cmd_valid |=> comm_state_q == $past(st_cmd)) else $error("state missed");
	enable_map_a: assert property (sdo_enable == (comm_state_q != 2'h0) && pdo_enable == comm_state_q[1]
		&& pdo_out_enable == (comm_state_q == 2'h3)) else $error("enables wrong");
	cfg_refuse_a: assert property (pd_cfg_valid && (pd_in_bytes > PD_MAX_BYTES || pd_out_bytes > PD_MAX_BYTES)
		|=> pd_cfg_err_q && $stable(pd_in_len_q) && $stable(pd_out_len_q)) else $error("oversize taken");
	run_op_a: assert property ((comm_state_q == 2'h3) [*3] |-> run_lamp) else $error("run lamp dark");
	err_crit_a: assert property (err_code == 3'h1 [*3] |-> err_lamp) else $error("error lamp dark");
	link_dark_a: assert property (!in_link [*3] |-> !in_link_lamp) else $error("link lamp lit");
	out_dark_a: assert property ((!out_link) [*3] |-> !out_link_lamp) else $error("out lamp lit");
	flicker_restart_a: assert property (in_link && $rose(in_activity) |-> lit_run) else $error("no restart");
endmodule // fsi_status_monitor
bind fsi_status_indicators fsi_status_monitor #(.MS_CYCLES(MS_CYCLES), .PD_MAX_BYTES(PD_MAX_BYTES)) u_mon (
	.clk_sys(clk_sys), .rst_b(rst_b), .st_cmd_valid(st_cmd_valid), .st_cmd(st_cmd), .err_code(err_code),
	.in_link(in_link), .in_activity(in_activity), .out_link(out_link), .pd_cfg_valid(pd_cfg_valid),
	.pd_in_bytes(pd_in_bytes), .pd_out_bytes(pd_out_bytes), .comm_state_q(comm_state_q),
	.pd_in_len_q(pd_in_len_q), .pd_out_len_q(pd_out_len_q), .pd_cfg_err_q(pd_cfg_err_q),
	.sdo_enable(sdo_enable), .pdo_enable(pdo_enable), .pdo_out_enable(pdo_out_enable), .run_lamp(run_lamp),
	.err_lamp(err_lamp), .in_link_lamp(in_link_lamp), .out_link_lamp(out_link_lamp));
`default_nettype wire

// ==== verification/fsi_master_model.sv ====
// behavioural fieldbus master issuing state commands
`timescale 1ns/1ps
`default_nettype none
module fsi_master_model (
	// clock
	input  wire logic       clk_sys,
	// state command
	output var  logic       st_cmd_valid,
	output var  logic [1:0] st_cmd
);
	initial begin
		st_cmd_valid = 1'b0;
		st_cmd       = 2'h0;
	end
	task command(input logic [1:0] s);
		begin
			@(negedge clk_sys);
			st_cmd_valid = 1'b1;
			st_cmd       = s;
			@(negedge clk_sys);
			st_cmd_valid = 1'b0;
			st_cmd       = ~s;
		end
	endtask
endmodule // fsi_master_model
`default_nettype wire

// ==== verification/tb_fieldbus_slave_status_indicators.sv ====
// self-checking bench of the status indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_slave_status_indicators;
	logic       clk_sys = 1'b0, rst_b = 1'b0, pd_cfg_valid = 1'b0;
	logic       in_link = 1'b0, in_activity = 1'b0, out_link = 1'b0, out_activity = 1'b0;
	logic [2:0] err_code = 3'h0;
	logic [8:0] pd_in_bytes = 9'h000, pd_out_bytes = 9'h000;
	wire        st_cmd_valid, sdo_enable, pdo_enable, pdo_out_enable, pd_cfg_err_q;
	wire        run_lamp, err_lamp, in_link_lamp, out_link_lamp;
	wire  [1:0] st_cmd, comm_state_q;
	wire  [8:0] pd_in_len_q, pd_out_len_q;
	integer     miscompares = 0, n_compared = 0, seed = 32'hBB9D545D, i, e_in = 0, e_out = 0;
	integer     q[$];
	localparam integer MS_CYCLES = 4;
	always #12.5 clk_sys = ~clk_sys;
	fsi_master_model M (.clk_sys(clk_sys), .st_cmd_valid(st_cmd_valid), .st_cmd(st_cmd));
	fsi_status_indicators #(.MS_CYCLES(MS_CYCLES)) DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .st_cmd_valid(st_cmd_valid), .st_cmd(st_cmd), .err_code(err_code),
		.in_link(in_link), .in_activity(in_activity), .out_link(out_link), .out_activity(out_activity),
		.pd_cfg_valid(pd_cfg_valid), .pd_in_bytes(pd_in_bytes), .pd_out_bytes(pd_out_bytes),
		.comm_state_q(comm_state_q), .pd_in_len_q(pd_in_len_q), .pd_out_len_q(pd_out_len_q),
		.pd_cfg_err_q(pd_cfg_err_q), .sdo_enable(sdo_enable), .pdo_enable(pdo_enable),
		.pdo_out_enable(pdo_out_enable), .run_lamp(run_lamp), .err_lamp(err_lamp),
		.in_link_lamp(in_link_lamp), .out_link_lamp(out_link_lamp));
	task cmp_val(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// lengths carry one cycle of slack at each segment edge
	task cmp_len(input string nm, input integer e, input integer g);
		n_compared++;
		if (g < e - 1 || g > e + 1) begin
			miscompares++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task report_and_stop;
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function logic lamp(input integer w);
		case (w)
			0: lamp = run_lamp;
			1: lamp = err_lamp;
			2: lamp = in_link_lamp;
			default: lamp = out_link_lamp;
		endcase
	endfunction
	// pattern p: 0 off, 1 on, 2 flicker, 3 blink, 4 single, 5 double; timed lit first
	task chk_lamp(input integer w, input integer p);
		integer k, n;
		logic   v;
		begin
			q = {};
			for (k = 0; k < 4; k++)
				q.push_back(MS_CYCLES * (p == 2 ? 50 : (p == 4 && k[0]) || (p == 5 && k == 3) ? 1000 : 200));
			repeat (2) @(negedge clk_sys);
			if (p < 2) begin
				repeat (40) @(negedge clk_sys) cmp_val("lamp", 9'(p), lamp(w));
			end else begin
				for (k = 0; k < (p == 4 ? 2 : 4); k++) begin
					v = lamp(w);
					cmp_val("lamp level", !k[0], v);
					for (n = 0; lamp(w) === v && n < 9000; n++)
						@(negedge clk_sys);
					cmp_len("segment", q.pop_front(), n);
				end
			end
		end
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		cmp_val("state", 9'h000, comm_state_q);
		chk_lamp(0, 0);
		for (i = 1; i < 5; i++) begin
			M.command(2'(i));
			cmp_val("state", 9'(i % 4), comm_state_q);
			cmp_val("enables", {i % 4 != 0, i % 4 >= 2, i % 4 == 3}, {sdo_enable, pdo_enable, pdo_out_enable});
			chk_lamp(0, i == 1 ? 3 : i == 2 ? 4 : i == 3 ? 1 : 0);
		end
		// reset in mid-run from operational returns to init
		M.command(2'h3);
		rst_b = 1'b0;
		@(negedge clk_sys);
		cmp_val("state", 9'h000, comm_state_q);
		cmp_val("run lamp", 9'h000, run_lamp);
		rst_b = 1'b1;
		chk_lamp(0, 0);
		// unused codes above watchdog show as no error
		for (i = 1; i < 9; i++) begin
			err_code = 3'(i % 8);
			chk_lamp(1, i == 1 ? 1 : i >= 5 ? 0 : i + 1);
		end
		for (i = 0; i < 6; i++) begin
			{in_link, in_activity}   = i < 3 ? {i % 3 > 0, i % 3 == 2} : 2'h0;
			{out_link, out_activity} = i < 3 ? 2'h0 : {i % 3 > 0, i % 3 == 2};
			chk_lamp(2 + i / 3, i % 3);
		end
		// random sizes around the limit, both boundaries first
		pd_cfg_valid = 1'b1;
		for (i = 0; i < 24; i++) begin
			pd_in_bytes  = i == 0 ? 9'h100 : i == 1 ? 9'h101 : 9'($unsigned($random(seed)) % 300);
			pd_out_bytes = i == 0 ? 9'h100 : i == 2 ? 9'h101 : 9'($unsigned($random(seed)) % 300);
			@(negedge clk_sys);
			if (pd_in_bytes <= 256 && pd_out_bytes <= 256) begin
				e_in  = pd_in_bytes;
				e_out = pd_out_bytes;
			end
			cmp_val("pd in", 9'(e_in), pd_in_len_q);
			cmp_val("pd out", 9'(e_out), pd_out_len_q);
			cmp_val("pd err", pd_in_bytes > 256 || pd_out_bytes > 256, pd_cfg_err_q);
		end
		pd_cfg_valid = 1'b0;
		report_and_stop;
	end
	initial begin
		#(25 * 60000);
		miscompares++;
		report_and_stop;
	end
endmodule // tb_fieldbus_slave_status_indicators
`default_nettype wire
